// ===== hdl/bcs_supervisor.v
`timescale 1ns/10ps
`default_nettype none
`include "bcs_regs.vh"

module bcs_supervisor #(
	parameter integer NCH           = 4,
	parameter integer US_CYCLES     = `BCS_US_CYCLES,
	parameter integer OC_RESTART_US = `BCS_OC_RESTART_US
) (
	input  wire              clk_i,
	input  wire              rst_i,
	input  wire [NCH-1:0]    ch_en_i,
	input  wire [NCH*10-1:0] vout_adc_i,
	input  wire [NCH*7-1:0]  isense_adc_i,
	input  wire [NCH*7-1:0]  channel_voltage_target_i,
	input  wire [NCH*2-1:0]  overvoltage_threshold_config_i,
	input  wire [NCH-1:0]    ov_force_low_i,
	input  wire [7:0]        follower_config_low_i,
	input  wire [7:0]        follower_config_high_i,
	input  wire [NCH*8-1:0]  current_limit_config_i,
	input  wire [NCH*16-1:0] soft_start_timing_i,
	input  wire [NCH*16-1:0] soft_stop_timing_i,
	input  wire [NCH*8-1:0]  pgood_upper_bound_i,
	input  wire [NCH*8-1:0]  pgood_lower_bound_i,
	input  wire [NCH*8-1:0]  pgood_delay_i,
	input  wire [7:0]        switching_freq_select_i,
	input  wire [NCH-1:0]    ov_flag_clear_i,
	input  wire [NCH-1:0]    oc_flag_clear_i,
	input  wire [3*NCH-1:0]  indication_route_i,
	output wire [NCH-1:0]    voltage_temp_fault_flags_o,
	output wire [NCH-1:0]    overcurrent_fault_flags_o,
	output wire [NCH-1:0]    overcurrent_warning_flags_o,
	output wire [7:0]        ramp_and_pgood_status_o,
	output wire [NCH-1:0]    pwm_enable_o,
	output wire [NCH-1:0]    low_side_gate_o,
	output wire [NCH*7-1:0]  ramp_ref_o,
	output reg  [2:0]        osc_select_o,
	output reg  [7:0]        pwm_period_o,
	output reg               freq_supported_o,
	output reg               indication_pin_o
);

	// ----------------------------------------
	// microsecond tick
	// ----------------------------------------
	reg  [6:0]     us_cnt_reg;
	reg            us_tick_reg;
	wire [15:0]    fcfg = {follower_config_high_i, follower_config_low_i};
	wire [NCH-1:0] ov_trip;
	wire [NCH-1:0] oc_trip;
	reg  [NCH-1:0] ov_flag_reg;
	reg  [NCH-1:0] oc_flag_reg;
	reg  [NCH-1:0] warn_reg;
	reg  [NCH-1:0] ss_reg;
	reg  [NCH-1:0] pg_reg;
	reg  [NCH-1:0] pwm_reg;
	reg  [NCH-1:0] lsg_reg;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			us_cnt_reg  <= 7'h00;
			us_tick_reg <= 1'b0;
		end else if (us_cnt_reg == US_CYCLES[6:0] - 7'h01) begin
			us_cnt_reg  <= 7'h00;
			us_tick_reg <= 1'b1;
		end else begin
			us_cnt_reg  <= us_cnt_reg + 7'h01;
			us_tick_reg <= 1'b0;
		end
	end

	assign voltage_temp_fault_flags_o  = ov_flag_reg;
	assign overcurrent_fault_flags_o   = oc_flag_reg;
	assign overcurrent_warning_flags_o = warn_reg;
	assign ramp_and_pgood_status_o     = {pg_reg, ss_reg};
	assign pwm_enable_o                = pwm_reg;
	assign low_side_gate_o             = lsg_reg;

	// ----------------------------------------
	// per-channel supervision
	// ----------------------------------------
	genvar g;
	generate
	for (g = 0; g < NCH; g = g + 1) begin : ch
		reg  [2:0]  st_reg;
		reg  [2:0]  st_next;
		reg  [17:0] tmr_reg;
		reg  [6:0]  ref_reg;
		wire [9:0]  vo   = vout_adc_i[g*10 +: 10];
		wire [6:0]  isn  = isense_adc_i[g*7 +: 7];
		wire [6:0]  tgt  = channel_voltage_target_i[g*7 +: 7];
		wire [1:0]  ovs  = overvoltage_threshold_config_i[g*2 +: 2];
		wire [7:0]  ilim = current_limit_config_i[g*8 +: 8];
		wire [15:0] sst  = soft_start_timing_i[g*16 +: 16];
		wire [15:0] spt  = soft_stop_timing_i[g*16 +: 16];
		wire [9:0]  pgu  = {2'b00, pgood_upper_bound_i[g*8 +: 8]};
		wire [9:0]  pgl  = {2'b00, pgood_lower_bound_i[g*8 +: 8]};
		wire [7:0]  pgd  = pgood_delay_i[g*8 +: 8];
		wire [3:0]  lead = {fcfg[12+g], fcfg[8+g], fcfg[4+g], fcfg[g]};
		// target in 10mV units
		wire [9:0]  vt10 = {3'b000, tgt} * `BCS_VT_MULT;
		wire [9:0]  ofs_lo = `BCS_OV_BASE + {8'h00, ovs} * `BCS_OV_STEP;
		wire [9:0]  ofs  = (tgt > `BCS_OV_HI_CODE) ?
		                   {ofs_lo[8:0], 1'b0} : ofs_lo;
		wire        armed = (st_reg != `BCS_ST_OFF) &&
		                    (st_reg != `BCS_ST_OV_LATCH) &&
		                    ch_en_i[g];
		wire        drive = (st_reg == `BCS_ST_RAMP) ||
		                    (st_reg == `BCS_ST_ON) ||
		                    (st_reg == `BCS_ST_STOP_DLY) ||
		                    (st_reg == `BCS_ST_STOP_RAMP);
		wire [7:0]  imax = {2'b00, ilim[`BCS_IL_MAX_MSB:`BCS_IL_MAX_LSB]};
		wire [7:0]  wofs = ({6'h00, ilim[`BCS_IL_WARN_MSB:`BCS_IL_WARN_LSB]}
		                   + 8'h01) * `BCS_IL_WARN_UNITS;
		wire        warn_now = ({1'b0, isn} + wofs) >= imax;
		wire [17:0] ss_dly = {12'h000, sst[`BCS_TM_DLY_MSB:`BCS_TM_DLY_LSB]}
		                   * `BCS_DLY_STEP_US;
		wire [17:0] sp_dly = {12'h000, spt[`BCS_TM_DLY_MSB:`BCS_TM_DLY_LSB]}
		                   * `BCS_DLY_STEP_US;
		wire [17:0] ss_stp = {8'h00, sst[`BCS_TM_STEP_MSB:`BCS_TM_STEP_LSB]};
		wire [17:0] sp_stp = {8'h00, spt[`BCS_TM_STEP_MSB:`BCS_TM_STEP_LSB]};
		wire [17:0] pg_dly = {10'h000, pgd} * `BCS_DLY_STEP_US;
		wire        in_win = (vo >= pgl * `BCS_PG_MULT) &&
		                     (vo <= pgu * `BCS_PG_MULT);
		wire        ov_kill = ov_trip[g] | (|(ov_trip & lead));
		wire        oc_kill = oc_trip[g] | (|(oc_trip & lead));

		assign ov_trip[g] = armed && (vo > vt10 + ofs);
		assign oc_trip[g] = drive && ({1'b0, isn} > imax);
		assign ramp_ref_o[g*7 +: 7] = ref_reg;

		always @* begin
			st_next = st_reg;
			case (st_reg)
			`BCS_ST_OFF: begin
				if (ch_en_i[g])
					st_next = `BCS_ST_DELAY;
			end
			`BCS_ST_DELAY: begin
				if (!ch_en_i[g])
					st_next = `BCS_ST_OFF;
				else if (tmr_reg >= ss_dly)
					st_next = `BCS_ST_RAMP;
			end
			`BCS_ST_RAMP: begin
				if (!ch_en_i[g])
					st_next = `BCS_ST_STOP_DLY;
				else if (ref_reg >= tgt)
					st_next = `BCS_ST_ON;
			end
			`BCS_ST_ON: begin
				if (!ch_en_i[g])
					st_next = `BCS_ST_STOP_DLY;
			end
			`BCS_ST_STOP_DLY: begin
				if (tmr_reg >= sp_dly)
					st_next = `BCS_ST_STOP_RAMP;
			end
			`BCS_ST_STOP_RAMP: begin
				if (ref_reg == 7'h00)
					st_next = `BCS_ST_OFF;
			end
			`BCS_ST_OV_LATCH: begin
				if (!ch_en_i[g])
					st_next = `BCS_ST_OFF;
			end
			`BCS_ST_OC_WAIT: begin
				if (!ch_en_i[g])
					st_next = `BCS_ST_OFF;
				else if (tmr_reg >= OC_RESTART_US[17:0])
					st_next = `BCS_ST_DELAY;
			end
			default: st_next = `BCS_ST_OFF;
			endcase
			if (ov_kill && st_reg != `BCS_ST_OFF)
				st_next = `BCS_ST_OV_LATCH;
			else if (oc_kill && drive)
				st_next = `BCS_ST_OC_WAIT;
		end

		always @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				st_reg         <= `BCS_ST_OFF;
				tmr_reg        <= 18'h00000;
				ref_reg        <= 7'h00;
				ov_flag_reg[g] <= 1'b0;
				oc_flag_reg[g] <= 1'b0;
				warn_reg[g]    <= 1'b0;
				ss_reg[g]      <= 1'b0;
				pg_reg[g]      <= 1'b0;
				pwm_reg[g]     <= 1'b0;
				lsg_reg[g]     <= 1'b0;
			end else begin
				st_reg <= st_next;
				// timer restarts on every state change
				if (st_next != st_reg)
					tmr_reg <= 18'h00000;
				else if (st_reg == `BCS_ST_RAMP && us_tick_reg &&
				         tmr_reg >= ss_stp) begin
					tmr_reg <= 18'h00000;
					ref_reg <= ref_reg + 7'h01;
				end else if (st_reg == `BCS_ST_STOP_RAMP &&
				             us_tick_reg && tmr_reg >= sp_stp) begin
					tmr_reg <= 18'h00000;
					if (ref_reg != 7'h00)
						ref_reg <= ref_reg - 7'h01;
				end else if (us_tick_reg && tmr_reg != 18'h3ffff)
					tmr_reg <= tmr_reg + 18'h00001;
				if (st_next == `BCS_ST_DELAY || st_next == `BCS_ST_OFF ||
				    st_next == `BCS_ST_OV_LATCH ||
				    st_next == `BCS_ST_OC_WAIT)
					ref_reg <= 7'h00;
				else if (st_next == `BCS_ST_ON && st_reg == `BCS_ST_RAMP)
					ref_reg <= tgt;
				ov_flag_reg[g] <= ov_trip[g] |
				                  (ov_flag_reg[g] & ~ov_flag_clear_i[g]);
				oc_flag_reg[g] <= oc_trip[g] |
				                  (oc_flag_reg[g] & ~oc_flag_clear_i[g]);
				warn_reg[g]    <= drive & warn_now;
				ss_reg[g]      <= (st_next == `BCS_ST_DELAY) ||
				                  (st_next == `BCS_ST_RAMP);
				pg_reg[g]      <= (st_reg == `BCS_ST_ON) &&
				                  (st_next == `BCS_ST_ON) &&
				                  (tmr_reg >= pg_dly) && in_win;
				pwm_reg[g]     <= freq_supported_o &&
				                  ((st_next == `BCS_ST_RAMP) ||
				                   (st_next == `BCS_ST_ON) ||
				                   (st_next == `BCS_ST_STOP_DLY) ||
				                   (st_next == `BCS_ST_STOP_RAMP));
				lsg_reg[g]     <= (st_next == `BCS_ST_OV_LATCH) &&
				                  ov_force_low_i[g];
			end
		end
	end
	endgenerate

	// ----------------------------------------
	// switching frequency decode
	// ----------------------------------------
	wire [2:0] osc_code = switching_freq_select_i[`BCS_SF_OSC_MSB:`BCS_SF_OSC_LSB];
	wire [2:0] div_code = switching_freq_select_i[`BCS_SF_DIV_MSB:`BCS_SF_DIV_LSB];
	// oscillator in 3.2MHz units: 15 down to 8
	wire [4:0] osc_units = `BCS_SF_OSC_TOP - {2'b00, osc_code};
	wire [5:0] lhs       = {osc_units, 1'b0};
	wire [5:0] rhs       = ({3'b000, div_code} + 6'h01) * 6'h03;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			osc_select_o     <= 3'h0;
			pwm_period_o     <= 8'h00;
			freq_supported_o <= 1'b0;
		end else begin
			osc_select_o     <= osc_code;
			pwm_period_o     <= ({5'h00, div_code} + 8'h01)
			                    << `BCS_SF_CYC_PER;
			freq_supported_o <= (div_code != 3'h0) && (lhs >= rhs);
		end
	end

	// ----------------------------------------
	// indication pin routing
	// ----------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			indication_pin_o <= 1'b0;
		else
			indication_pin_o <= |({warn_reg, oc_flag_reg, ov_flag_reg} &
			                      indication_route_i);
	end

endmodule
`default_nettype wire

// ===== hdl/bcs_regs.vh
`ifndef BCS_REGS_VH
`define BCS_REGS_VH

// ----------------------------------------
// clock and time bases
// ----------------------------------------
`define BCS_CLK_NS        10
`define BCS_US_NS         1000
`define BCS_US_CYCLES     (`BCS_US_NS / `BCS_CLK_NS)
`define BCS_DLY_STEP_US   18'h000fa
`define BCS_OC_RESTART_US 200000

// ----------------------------------------
// soft-start / soft-stop timing fields
// ----------------------------------------
`define BCS_TM_DLY_MSB    15
`define BCS_TM_DLY_LSB    10
`define BCS_TM_STEP_MSB   9
`define BCS_TM_STEP_LSB   0

// ----------------------------------------
// current limit fields and units
// ----------------------------------------
`define BCS_IL_MAX_MSB    5
`define BCS_IL_MAX_LSB    0
`define BCS_IL_WARN_MSB   7
`define BCS_IL_WARN_LSB   6
`define BCS_IL_WARN_UNITS 8'h02

// ----------------------------------------
// switching frequency fields
// ----------------------------------------
`define BCS_SF_OSC_MSB    6
`define BCS_SF_OSC_LSB    4
`define BCS_SF_DIV_MSB    2
`define BCS_SF_DIV_LSB    0
`define BCS_SF_OSC_TOP    5'h0f
`define BCS_SF_CYC_PER    4

// ----------------------------------------
// voltage scaling in 10 mV units, except BCS_OV_HI_CODE, which is a target code
// ----------------------------------------
`define BCS_VT_MULT       10'h005
`define BCS_PG_MULT       10'h002
`define BCS_OV_BASE       10'h00f
`define BCS_OV_STEP       10'h005
`define BCS_OV_HI_CODE    7'h32

// ----------------------------------------
// channel states
// ----------------------------------------
`define BCS_ST_OFF        3'h0
`define BCS_ST_DELAY      3'h1
`define BCS_ST_RAMP       3'h2
`define BCS_ST_ON         3'h3
`define BCS_ST_STOP_DLY   3'h4
`define BCS_ST_STOP_RAMP  3'h5
`define BCS_ST_OV_LATCH   3'h6
`define BCS_ST_OC_WAIT    3'h7

`endif

// ===== tb/bcs_supervisor_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// port checks for the supervisor
// ------------------------------
module bcs_supervisor_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [27:0] isense_adc_i,
	input wire logic [3:0]  ov_force_low_i,
	input wire logic [7:0]  follower_config_low_i,
	input wire logic [31:0] current_limit_config_i,
	input wire logic [7:0]  switching_freq_select_i,
	input wire logic [3:0]  voltage_temp_fault_flags_o,
	input wire logic [3:0]  overcurrent_fault_flags_o,
	input wire logic [3:0]  overcurrent_warning_flags_o,
	input wire logic [7:0]  ramp_and_pgood_status_o,
	input wire logic [3:0]  pwm_enable_o,
	input wire logic [3:0]  low_side_gate_o,
	input wire logic [27:0] ramp_ref_o,
	input wire logic [7:0]  pwm_period_o,
	input wire logic        freq_supported_o
);
	wire [2:0] dv = switching_freq_select_i[2:0];
	wire       f_ok = (dv != 3'h0) &&
		((5'h0f - switching_freq_select_i[6:4]) * 2 >= (dv + 5'h01) * 3);
	wire       w_ok = {1'b0, isense_adc_i[6:0]} + 8'h02 +
		{current_limit_config_i[7:6], 1'b0} >= {2'h0, current_limit_config_i[5:0]};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_ov; $rose(voltage_temp_fault_flags_o[0]); endsequence
	sequence s_oc; $rose(overcurrent_fault_flags_o[0]); endsequence
	property p_ov_off;
		s_ov |-> !pwm_enable_o[0] && !(follower_config_low_i[1] && pwm_enable_o[1]);
	endproperty
	a_ov_off: assert property (p_ov_off) else $error("ov trip left drivers on");
	property p_ov_lsg; s_ov |-> low_side_gate_o[0] == $past(ov_force_low_i[0]); endproperty
	a_ov_lsg: assert property (p_ov_lsg) else $error("low side gate wrong");
	property p_oc_wait; s_oc |-> !pwm_enable_o[0] [*8]; endproperty
	a_oc_wait: assert property (p_oc_wait) else $error("oc restart too soon");
	property p_period;
		!$past(rst_i) |-> pwm_period_o == {$past(dv) + 4'h1, 4'h0};
	endproperty
	a_period: assert property (p_period) else $error("period wrong");
	property p_sup; !$past(rst_i) |-> freq_supported_o == $past(f_ok); endproperty
	a_sup: assert property (p_sup) else $error("supported flag wrong");
	property p_unsup; !freq_supported_o [*2] |-> pwm_enable_o == 4'h0; endproperty
	a_unsup: assert property (p_unsup) else $error("pwm on unsupported");
	property p_pg; ramp_and_pgood_status_o[4] |-> !ramp_and_pgood_status_o[0]; endproperty
	a_pg: assert property (p_pg) else $error("pgood in soft-start");
	property p_warn; overcurrent_warning_flags_o[0] |-> $past(w_ok); endproperty
	a_warn: assert property (p_warn) else $error("warning below threshold");
	property p_ramp;
		ramp_and_pgood_status_o[0] && $past(ramp_and_pgood_status_o[0])
			|-> ramp_ref_o[6:0] >= $past(ramp_ref_o[6:0]);
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp fell in soft-start");
endmodule
bind bcs_supervisor bcs_supervisor_chk bcs_supervisor_chk_i (.*);
`default_nettype wire

// ===== tb/bcs_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// power stage seen by the adcs
// ------------------------------
module bcs_stage_model (
	input  wire logic [27:0] ramp_i,
	input  wire logic [3:0]  pwm_i,
	input  wire logic [3:0]  lsg_i,
	input  wire logic [39:0] vbump_i,
	input  wire logic [27:0] icmd_i,
	output var  logic [39:0] vout_o,
	output var  logic [27:0] isense_o
);
	integer c;
	always @* begin
		for (c = 0; c < 4; c++) begin
			vout_o[c*10+:10] = lsg_i[c] ? 10'h000 :
				ramp_i[c*7+:7] * 10'h005 + vbump_i[c*10+:10];
			isense_o[c*7+:7] = pwm_i[c] ? icmd_i[c*7+:7] : 7'h00;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_i = 0, rst_i = 1;
	logic [3:0]  ch_en_i = '0, ov_force_low_i = 4'h1, ov_flag_clear_i = '0;
	logic [3:0]  oc_flag_clear_i = '0;
	logic [39:0] vout_adc_i, vbump = '0;
	logic [27:0] isense_adc_i, icmd = '0, ramp_ref_o;
	logic [27:0] channel_voltage_target_i = {7'h32, {3{7'h0a}}};
	logic [7:0]  overvoltage_threshold_config_i = '0;
	logic [7:0]  follower_config_low_i = 8'h02, follower_config_high_i = '0;
	logic [31:0] current_limit_config_i = {4{8'h14}};
	logic [63:0] soft_start_timing_i = {4{16'h0400}};
	logic [63:0] soft_stop_timing_i = {4{16'h0400}};
	logic [31:0] pgood_upper_bound_i = {4{8'h1a}};
	logic [31:0] pgood_lower_bound_i = {4{8'h18}};
	logic [31:0] pgood_delay_i = {4{8'h01}};
	logic [7:0]  switching_freq_select_i = 8'h01;
	logic [11:0] indication_route_i = 12'h001;
	logic [3:0]  voltage_temp_fault_flags_o, overcurrent_fault_flags_o;
	logic [3:0]  overcurrent_warning_flags_o, pwm_enable_o, low_side_gate_o;
	logic [7:0]  ramp_and_pgood_status_o, pwm_period_o;
	logic [2:0]  osc_select_o;
	logic        freq_supported_o, indication_pin_o;
	integer      err_total = 0, check_count = 0, cyc = 0, i;
	wire  [7:0]  st = ramp_and_pgood_status_o;
	wire  [3:0]  pwm = pwm_enable_o;
	// sel, period, supported
	logic [16:0] frow [6] = '{{8'h01, 8'h20, 1'b1}, {8'h75, 8'h60, 1'b0},
		{8'h65, 8'h60, 1'b1}, {8'h37, 8'h80, 1'b1}, {8'h47, 8'h80, 1'b0},
		{8'h30, 8'h10, 1'b0}};
	bcs_supervisor #(.US_CYCLES(4), .OC_RESTART_US(50)) bcs_supervisor_i (.*);
	bcs_stage_model bcs_stage_model_i (.ramp_i(ramp_ref_o), .pwm_i(pwm_enable_o),
		.lsg_i(low_side_gate_o), .vbump_i(vbump), .icmd_i(icmd),
		.vout_o(vout_adc_i), .isense_o(isense_adc_i));
	initial forever #5 clk_i = ~clk_i;
	task automatic chk(input string nm, input logic [9:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			finish_test;
		end
	end
	initial begin
		repeat (8) @(negedge clk_i);
		chk("status", st, 0);
		rst_i = 0;
		for (i = 0; i < 6; i++) begin
			switching_freq_select_i = frow[i][16:9];
			repeat (2) @(negedge clk_i);
			chk("period", pwm_period_o, frow[i][8:1]);
			chk("supported", freq_supported_o, frow[i][0]);
			chk("osc", osc_select_o, frow[i][15:13]);
		end
		switching_freq_select_i = 8'h01;
		ch_en_i = 4'h7;
		repeat (3) @(negedge clk_i);
		chk("ss", st[2:0], 3'h7);
		repeat (940) @(negedge clk_i);
		chk("pwm early", pwm[0], 0);
		for (i = 0; i < 100 && !pwm[0]; i++) @(negedge clk_i);
		chk("pwm on", pwm[2:0], 3'h7);
		for (i = 0; i < 100 && st[0]; i++) @(negedge clk_i);
		chk("ramp", ramp_ref_o[6:0], 7'h0a);
		repeat (900) @(negedge clk_i);
		chk("pg early", st[4], 0);
		for (i = 0; i < 200 && !st[4]; i++) @(negedge clk_i);
		vbump[9:0] = 10'h002;
		repeat (3) @(negedge clk_i);
		chk("pg", st[6:4], 3'h7);
		vbump[9:0] = 10'h003;
		repeat (3) @(negedge clk_i);
		chk("pg out", st[4], 0);
		vbump = '0;
		ch_en_i[2] = 0;
		repeat (950) @(negedge clk_i);
		chk("stop dly", pwm[2], 1);
		for (i = 0; i < 200 && pwm[2]; i++) @(negedge clk_i);
		chk("stop", {pwm[2], ramp_ref_o[20:14]}, 0);
		icmd[6:0] = 7'h12;
		repeat (3) @(negedge clk_i);
		chk("warn", overcurrent_warning_flags_o, 4'h1);
		icmd[6:0] = 7'h11;
		repeat (3) @(negedge clk_i);
		chk("warn off", overcurrent_warning_flags_o, 0);
		icmd[6:0] = 7'h15;
		repeat (3) @(negedge clk_i);
		chk("oc", {overcurrent_fault_flags_o, pwm}, 8'h10);
		icmd = '0;
		oc_flag_clear_i = 4'h1;
		@(negedge clk_i);
		oc_flag_clear_i = '0;
		repeat (140) @(negedge clk_i);
		chk("oc wait", {overcurrent_fault_flags_o, st[1:0], pwm[1:0]}, 0);
		for (i = 0; i < 100 && !st[0]; i++) @(negedge clk_i);
		chk("restart", st[1:0], 2'h3);
		vbump[9:0] = 10'h041;
		repeat (3) @(negedge clk_i);
		chk("ov edge", voltage_temp_fault_flags_o, 0);
		vbump[9:0] = 10'h042;
		repeat (3) @(negedge clk_i);
		chk("ov", voltage_temp_fault_flags_o, 4'h1);
		chk("follow", st[1:0], 0);
		chk("gate", low_side_gate_o, 4'h1);
		chk("pin", indication_pin_o, 1);
		vbump = '0;
		ov_flag_clear_i = 4'h1;
		@(negedge clk_i);
		ov_flag_clear_i = '0;
		repeat (300) @(negedge clk_i);
		chk("latched", {st[0], pwm[0], low_side_gate_o[0], indication_pin_o}, 4'h2);
		ch_en_i = '0;
		repeat (3) @(negedge clk_i);
		ch_en_i = 4'h3;
		repeat (3) @(negedge clk_i);
		chk("reenable", {st[1:0], low_side_gate_o[0]}, 3'h6);
		finish_test;
	end
endmodule
`default_nettype wire
